// File: logic/config_userid_nvm_access.sv
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "cfg_nvm_defs.svh"

// What this block does
// [R1] Region codes 01 and 11 route table accesses to configuration space.
// [R2] Table read copies the byte at the pointer into the data latch.
// [R3] Processor stalls during a configuration-space read, resumes when delivered.
// [R4] Reads of invalid locations clear the data latch to zero.
// [R5] Only user ID bytes and configuration words are writable.
// [R6] Write-start is refused unless write-enable is already set.
// [R7] Hardware clears write-enable only on reset; otherwise only software writes change it.
// [R8] Software should keep write-enable clear except during updates.
// [R9] Software loads pointer and latch, then unlocks, before config writes.
// [R10] Protected or invalid config write clears write-start, sets error.
// [R11] Config write programs one byte with implicit erase, no erase-select.
// [R12] Config write stalls, then clears write-start and sets completion flag.
// [R13] New config value takes effect as the processor resumes.
// [R14] Software erases a user ID byte before programming it.
// [R15] User ID erase sets one byte to FF, stalls, flags completion.
// [R16] Software unlocks before every user ID erase or program.
// [R17] User ID program: table write, write command, one byte, stall.
// [R18] Invalid pointer on user ID operation clears write-start, sets error.
// [R19] Reset during a high-voltage operation sets the write-error flag.
// [R20] Write-start accepted only after a complete, uninterrupted unlock.
module config_userid_nvm_access
  import cfg_nvm_pkg::*;
#(
  parameter logic [7:0] UNLOCK_KEY1 = `UNLOCK_KEY1,
  parameter logic [7:0] UNLOCK_KEY2 = `UNLOCK_KEY2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic config_write_protect_i,
  output logic cpu_stall_o,
  output logic memory_op_irq_flag_o,
  output logic write_error_flag_o,
  output logic [79:0] config_word_o
);

  localparam logic [11:0] WRITE_CNT = 12'(`WRITE_CYCLES - 1);
  localparam logic [11:0] READ_CNT = 12'(`READ_CYCLES - 1);

  state_t state_r;
  logic [11:0] cnt_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [1:0] region_r;
  logic erase_sel_r;
  logic write_enable_bit_r;
  logic wr_r;
  logic werr_r;
  logic irq_r;
  logic [21:0] tptr_r;
  logic [7:0] tlat_r;
  logic [7:0] hold_r;
  logic armed;
  logic [7:0] rdata;
  area_t area;
  logic in_cfg;
  logic bus_req;
  logic wr_acc;
  logic rd_acc;
  logic hit_mcon;
  logic hit_tptr;
  logic hit_tlat;
  logic hit_unlk;
  logic hit_stat;
  logic hit_tcmd;
  logic start_req;
  logic start_bad;
  logic start_ok;
  logic read_go;
  logic read_end;
  logic write_end;
  logic store_we;
  logic [7:0] store_data;
  logic [31:0] tptr_wr;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nv,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nv[i*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction : hit

  assign area = classify(tptr_r);
  assign tptr_wr = merge({10'h000, tptr_r}, wb_dat_i, wb_sel_i);
  assign in_cfg = (region_r == `REG_CFG_A) || (region_r == `REG_CFG_B); // R1

  // Bus answers only while idle, so the core is held off
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_r && state_r == ST_IDLE; // R3
  assign wr_acc = bus_req && wb_we_i;
  assign rd_acc = bus_req && !wb_we_i;

  assign hit_mcon = hit(wb_adr_i, `MCON_OFS);
  assign hit_tptr = hit(wb_adr_i, `TPTR_OFS);
  assign hit_tlat = hit(wb_adr_i, `TLAT_OFS);
  assign hit_unlk = hit(wb_adr_i, `UNLK_OFS);
  assign hit_stat = hit(wb_adr_i, `STAT_OFS);
  assign hit_tcmd = hit(wb_adr_i, `TCMD_OFS);

  // Write-start request from software
  assign start_req = wr_acc && hit_mcon && wb_sel_i[0]
                     && wb_dat_i[`MCON_WR] && !wr_r;
  assign start_ok = start_req && write_enable_bit_r && armed; // R6 R20

  // Only user IDs and, while config_write_protect_i is high, config words are writable
  assign start_bad = !in_cfg || !(area == AREA_UID
                     || (area == AREA_CFG && config_write_protect_i)); // R5 R10 R18

  assign read_go = wr_acc && hit_tcmd && wb_sel_i[0]
                   && wb_dat_i[`TCMD_RD]; // R2
  assign read_end = state_r == ST_READ && cnt_r == 12'h000;
  assign write_end = state_r == ST_WRITE && cnt_r == 12'h000;
  assign store_we = write_end;

  // Config bytes take the latch; user IDs take the table-write holding byte
  assign store_data = (area == AREA_CFG) ? tlat_r : hold_r; // R9 R17

  cfg_nvm_unlock #(
    .KEY1(UNLOCK_KEY1),
    .KEY2(UNLOCK_KEY2)
  ) u_unlock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .key_we_i(wr_acc && hit_unlk && wb_sel_i[0]),
    .key_i(wb_dat_i[7:0]),
    .other_we_i(wr_acc && !hit_unlk),
    .consume_i(1'b0),
    .armed_o(armed)
  );

  cfg_nvm_store u_store (
    .clk_i(clk_i),
    .por_i(por_i),
    .addr_i(tptr_r),
    .we_i(store_we),
    .erase_i(erase_sel_r && area == AREA_UID), // R14
    .wdata_i(store_data),
    .rdata_o(rdata),
    .config_word_o(config_word_o) // R13
  );

  // Sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 12'h000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start_ok && !start_bad)
          begin
            state_r <= ST_WRITE; // R11 R12 R15 R17
            cnt_r <= WRITE_CNT;
          end
          else if (read_go)
          begin
            state_r <= ST_READ; // R3
            cnt_r <= READ_CNT;
          end
        end
        ST_READ, ST_WRITE:
        begin
          if (cnt_r == 12'h000)
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r - 12'h001;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  assign cpu_stall_o = state_r != ST_IDLE; // R3 R12 R15

  // Control fields of memory_control_one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      region_r <= 2'h0;
      erase_sel_r <= 1'b0;
      write_enable_bit_r <= 1'b0;
    end
    else if (wr_acc && hit_mcon && wb_sel_i[0])
    begin
      region_r <= wb_dat_i[`MCON_REG_LO +: 2];
      erase_sel_r <= wb_dat_i[`MCON_ERASE];
      write_enable_bit_r <= wb_dat_i[`MCON_WRITE_ENABLE_BIT]; // R7
    end
  end

  // Write-start: bad requests never set it; completion clears it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wr_r <= 1'b0;
    else if (start_ok && !start_bad)
      wr_r <= 1'b1;
    else if (write_end)
      wr_r <= 1'b0; // R12
  end

  // Error flag survives a plain reset; power-on clears it
  always_ff @(posedge clk_i)
  begin
    if (por_i)
      werr_r <= 1'b0;
    else if (rst_i)
    begin
      if (state_r == ST_WRITE)
        werr_r <= 1'b1; // R19
    end
    else if (start_ok && start_bad)
      werr_r <= 1'b1; // R10 R18
    else if (wr_acc && hit_mcon && wb_sel_i[0])
      werr_r <= wb_dat_i[`MCON_WERR];
  end

  // Completion flag, write one to clear, set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_r <= 1'b0;
    else if (write_end)
      irq_r <= 1'b1; // R12 R15
    else if (wr_acc && hit_stat && wb_sel_i[0] && wb_dat_i[`STAT_IRQ])
      irq_r <= 1'b0;
  end

  // Table pointer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tptr_r <= 22'h00_0000;
    else if (wr_acc && hit_tptr)
      tptr_r <= tptr_wr[21:0]; // R2
  end

  // Table data latch: loaded by software or by a finished read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tlat_r <= 8'h00;
    else if (read_end)
    begin
      if (in_cfg && area != AREA_NONE)
        tlat_r <= rdata; // R2
      else
        tlat_r <= 8'h00; // R4
    end
    else if (wr_acc && hit_tlat && wb_sel_i[0])
      tlat_r <= wb_dat_i[7:0];
  end

  // Table write copies the latch into the program holding byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_r <= `ERASED_BYTE;
    else if (wr_acc && hit_tcmd && wb_sel_i[0] && wb_dat_i[`TCMD_WT])
      hold_r <= tlat_r; // R17
  end

  // Bus answer: one cycle ack, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= 32'h0000_0000;
    else if (rd_acc)
    begin
      dat_r <= 32'h0000_0000;
      if (hit_mcon)
      begin
        dat_r[`MCON_REG_LO +: 2] <= region_r;
        dat_r[`MCON_ERASE] <= erase_sel_r;
        dat_r[`MCON_WERR] <= werr_r;
        dat_r[`MCON_WRITE_ENABLE_BIT] <= write_enable_bit_r;
        dat_r[`MCON_WR] <= wr_r;
      end
      else if (hit_tptr)
        dat_r[21:0] <= tptr_r;
      else if (hit_tlat)
        dat_r[7:0] <= tlat_r;
      else if (hit_stat)
      begin
        dat_r[`STAT_IRQ] <= irq_r;
        dat_r[`STAT_BUSY] <= state_r != ST_IDLE;
        dat_r[`STAT_PROT] <= config_write_protect_i;
        dat_r[`STAT_ARMED] <= armed;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign memory_op_irq_flag_o = irq_r;
  assign write_error_flag_o = werr_r;

endmodule : config_userid_nvm_access

// File: inc/cfg_nvm_defs.svh
`ifndef CFG_NVM_DEFS_SVH
`define CFG_NVM_DEFS_SVH

// Register byte offsets
`define MCON_OFS 8'h00
`define TPTR_OFS 8'h04
`define TLAT_OFS 8'h08
`define UNLK_OFS 8'h0C
`define STAT_OFS 8'h10
`define TCMD_OFS 8'h14

// memory_control_one fields
`define MCON_REG_LO 0
`define MCON_ERASE 2
`define MCON_WERR 3
`define MCON_WRITE_ENABLE_BIT 4
`define MCON_WR 5

// Status fields
`define STAT_IRQ 0
`define STAT_BUSY 1
`define STAT_PROT 2
`define STAT_ARMED 3

// Table command fields
`define TCMD_RD 0
`define TCMD_WT 1

// Region select codes for configuration space
`define REG_CFG_A 2'h1
`define REG_CFG_B 2'h3

// Configuration space map
`define UID_BASE 22'h20_0000
`define UID_BYTES 16
`define DIA_BASE 22'h2C_0000
`define DIA_BYTES 8
`define CFG_BASE 22'h30_0000
`define CFG_BYTES 10
`define DID_BASE 22'h3F_FFFC
`define DID_BYTES 4

// Reset and fill values
`define ERASED_BYTE 8'hFF
`define CFG_RESET 80'hFFFF_FFFF_FFFF_FFFF_FFFF

// Unlock keys
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'hAA

// Timing
`define CLK_PERIOD_NS 10
`define WRITE_TIME_NS 20000
`define WRITE_CYCLES ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLES 2

`endif

// File: inc/cfg_nvm_pkg.sv
package cfg_nvm_pkg;

  typedef enum logic [2:0] {
    AREA_NONE,
    AREA_UID,
    AREA_DIA,
    AREA_CFG,
    AREA_DID
  } area_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } state_t;

  function automatic area_t classify(input logic [21:0] a);
    if (a >= 22'h20_0000 && a < 22'h20_0010)
      return AREA_UID;
    else if (a >= 22'h2C_0000 && a < 22'h2C_0008)
      return AREA_DIA;
    else if (a >= 22'h30_0000 && a < 22'h30_000A)
      return AREA_CFG;
    else if (a >= 22'h3F_FFFC)
      return AREA_DID;
    else
      return AREA_NONE;
  endfunction : classify

endpackage : cfg_nvm_pkg

// File: logic/cfg_nvm_unlock.sv
`timescale 1ns/1ps
`include "cfg_nvm_defs.svh"

module cfg_nvm_unlock
  import cfg_nvm_pkg::*;
#(
  parameter logic [7:0] KEY1 = `UNLOCK_KEY1,
  parameter logic [7:0] KEY2 = `UNLOCK_KEY2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic key_we_i,
  input wire logic [7:0] key_i,
  input wire logic other_we_i,
  input wire logic consume_i,
  output logic armed_o
);

  logic half_r;
  logic armed_r;

  // Any foreign write breaks the sequence; reads do not
  always_ff @(posedge clk_i)
  begin
    if (rst_i || other_we_i || consume_i)
    begin
      half_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else if (key_we_i)
    begin
      half_r <= (key_i == KEY1);
      armed_r <= half_r && (key_i == KEY2);
    end
  end

  assign armed_o = armed_r;

endmodule : cfg_nvm_unlock

// File: logic/cfg_nvm_store.sv
`timescale 1ns/1ps
`include "cfg_nvm_defs.svh"

module cfg_nvm_store
  import cfg_nvm_pkg::*;
#(
  parameter logic [63:0] DIA_VALUE = 64'h0123_4567_89AB_CDEF,
  // Arbitrary identification value
  parameter logic [31:0] DID_VALUE = 32'h1234_5678
)
(
  input wire logic clk_i,
  input wire logic por_i,
  input wire logic [21:0] addr_i,
  input wire logic we_i,
  input wire logic erase_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [79:0] config_word_o
);

  logic [7:0] uid_r [`UID_BYTES];
  logic [7:0] cfg_r [`CFG_BYTES];
  logic [3:0] idx;
  area_t area;

  assign area = classify(addr_i);
  assign idx = addr_i[3:0];

  // User ID programs only pull bits low, erase sets FF; config cells erase implicitly
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      for (int i = 0; i < `UID_BYTES; i++)
        uid_r[i] <= `ERASED_BYTE;
      for (int i = 0; i < `CFG_BYTES; i++)
        cfg_r[i] <= `ERASED_BYTE;
    end
    else if (we_i && area == AREA_UID)
      uid_r[idx] <= erase_i ? `ERASED_BYTE : (uid_r[idx] & wdata_i); // R15
    else if (we_i && area == AREA_CFG)
      cfg_r[idx] <= wdata_i; // R11
  end

  always_comb
  begin
    case (area)
      AREA_UID: rdata_o = uid_r[idx];
      AREA_CFG: rdata_o = cfg_r[idx];
      AREA_DIA: rdata_o = DIA_VALUE[{idx[2:0], 3'h0} +: 8];
      AREA_DID: rdata_o = DID_VALUE[{idx[1:0], 3'h0} +: 8];
      default: rdata_o = 8'h00;
    endcase
  end

  always_comb
  begin
    for (int i = 0; i < `CFG_BYTES; i++)
      config_word_o[i*8 +: 8] = cfg_r[i];
  end

endmodule : cfg_nvm_store

// File: testbench/cfg_nvm_chk.sv
`timescale 1ns/1ps
`include "cfg_nvm_defs.svh"
module cfg_nvm_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic cpu_stall_o,
  input wire logic memory_op_irq_flag_o,
  input wire logic write_error_flag_o,
  input wire logic [79:0] config_word_o
);
  int cnt_r;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Length of the running stall
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cpu_stall_o)
      cnt_r <= 0;
    else
      cnt_r <= cnt_r + 1;
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_one_pulse: assert property (wb_ack_o |-> s_pulse)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> s_req)
    else $error("ack without request");
  a_stall_length: assert property (
    $fell(cpu_stall_o) && !$past(rst_i) |->
    cnt_r == `READ_CYCLES || cnt_r == `WRITE_CYCLES)
    else $error("stall length wrong");
  a_irq_at_resume: assert property (
    $rose(memory_op_irq_flag_o) |-> $fell(cpu_stall_o))
    else $error("irq flag not at end of operation");
  a_cfg_at_resume: assert property ($changed(config_word_o) |->
    $fell(cpu_stall_o) || $past(por_i) || $past(por_i, 2))
    else $error("config changed outside resume");
  a_err_clear_cause: assert property ($fell(write_error_flag_o) |->
    $past(por_i) || $past(wb_we_i && wb_cyc_i))
    else $error("error flag cleared by itself");
  a_reset_sets_err: assert property (disable iff (1'b0)
    rst_i && cpu_stall_o && cnt_r > 2 |=> write_error_flag_o)
    else $error("reset in write left error clear");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !cpu_stall_o && !memory_op_irq_flag_o)
    else $error("outputs active after reset");
endmodule : cfg_nvm_chk

bind config_userid_nvm_access cfg_nvm_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .cpu_stall_o(cpu_stall_o), .memory_op_irq_flag_o(memory_op_irq_flag_o),
  .write_error_flag_o(write_error_flag_o), .config_word_o(config_word_o));

// File: testbench/cpu_model.sv
`timescale 1ns/1ps
`include "cfg_nvm_defs.svh"
module cpu_model (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  initial
  begin
    {wb_cyc_o, wb_stb_o, wb_we_o} = 3'h0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_dat_o <= d;
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1)
      @(posedge clk_i);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd
  // Region write also drops write enable between updates
  task automatic tread(input logic [21:0] p, input logic [1:0] rg,
                       output logic [31:0] q);
    wr(`TPTR_OFS, {10'h000, p});
    wr(`MCON_OFS, {30'h0000_0000, rg});
    wr(`TCMD_OFS, 32'h0000_0001);
    rd(`TLAT_OFS, q);
  endtask : tread
  task automatic op(input logic [21:0] p, input logic [7:0] d,
                    input logic [7:0] mc, input logic tw);
    wr(`TPTR_OFS, {10'h000, p});
    wr(`TLAT_OFS, {24'h00_0000, d});
    if (tw)
      wr(`TCMD_OFS, 32'h0000_0002);
    wr(`MCON_OFS, {24'h00_0000, mc & 8'hDF});
    wr(`UNLK_OFS, {24'h00_0000, `UNLOCK_KEY1});
    wr(`UNLK_OFS, {24'h00_0000, `UNLOCK_KEY2});
    wr(`MCON_OFS, {24'h00_0000, mc | 8'h20});
  endtask : op
endmodule : cpu_model

// File: testbench/testbench.sv
`timescale 1ns/1ps
`include "cfg_nvm_defs.svh"
module testbench;
  logic clk_i, rst_i, por_i, prot;
  logic cyc, stb, we, ack, stall, irq, err;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [79:0] cfg;
  int n_errors, n_checks, cyc_n;
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  config_userid_nvm_access u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .por_i(por_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .config_write_protect_i(prot), .cpu_stall_o(stall),
    .memory_op_irq_flag_o(irq), .write_error_flag_o(err),
    .config_word_o(cfg));
  cpu_model u_cpu (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat),
    .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel), .wb_dat_o(wdat));
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_mcon(input string nm, input logic [5:0] e);
    u_cpu.rd(`MCON_OFS, q);
    chk(nm, {26'h0, e}, {26'h0, q[5:0]});
  endtask : chk_mcon
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 40000)
    begin
      n_errors++;
      stop_test();
    end
  end
  initial
  begin
    rst_i = 1'b1;
    por_i = 1'b1;
    prot = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    u_cpu.tread(`CFG_BASE, 2'h1, q);
    chk("config read", 32'h0000_00FF, q);
    u_cpu.tread(`DID_BASE - 22'h1, 2'h3, q);
    chk("invalid read", 32'h0000_0000, q);
    u_cpu.wr(`MCON_OFS, 32'h0000_0001);
    u_cpu.wr(`UNLK_OFS, 32'h0000_0055);
    u_cpu.wr(`UNLK_OFS, 32'h0000_00AA);
    u_cpu.wr(`MCON_OFS, 32'h0000_0021);
    chk_mcon("start without enable", 6'h01);
    u_cpu.wr(`MCON_OFS, 32'h0000_0011);
    u_cpu.wr(`UNLK_OFS, 32'h0000_0055);
    u_cpu.wr(`TPTR_OFS, 32'h0030_0000);
    u_cpu.wr(`UNLK_OFS, 32'h0000_00AA);
    u_cpu.wr(`MCON_OFS, 32'h0000_0031);
    chk_mcon("broken unlock", 6'h11);
    u_cpu.op(`CFG_BASE + 22'h1, 8'h5A, 8'h11, 1'b0);
    chk_mcon("enable kept", 6'h11);
    u_cpu.rd(`STAT_OFS, q);
    chk("done flag", 32'h1, {31'h0, q[0]});
    chk("irq pin", 32'h1, {31'h0, irq});
    chk("config byte", 32'h5AFF, {16'h0, cfg[15:0]});
    u_cpu.wr(`STAT_OFS, 32'h0000_0001);
    prot <= 1'b0;
    u_cpu.op(`CFG_BASE, 8'h00, 8'h11, 1'b0);
    chk_mcon("protected write", 6'h19);
    chk("error pin", 32'h1, {31'h0, err});
    chk("config kept", 32'h5AFF, {16'h0, cfg[15:0]});
    prot <= 1'b1;
    u_cpu.op(`DIA_BASE, 8'h00, 8'h11, 1'b0);
    chk_mcon("read-only write", 6'h19);
    u_cpu.op(`UID_BASE + 22'hF, 8'h3C, 8'h13, 1'b1);
    u_cpu.tread(`UID_BASE + 22'hF, 2'h3, q);
    chk("id program", 32'h0000_003C, q);
    u_cpu.op(`UID_BASE + 22'hF, 8'h00, 8'h17, 1'b0);
    u_cpu.tread(`UID_BASE + 22'hF, 2'h3, q);
    chk("id erase", 32'h0000_00FF, q);
    u_cpu.op(`UID_BASE + 22'h10, 8'h3C, 8'h13, 1'b1);
    chk_mcon("invalid id write", 6'h1B);
    u_cpu.op(`CFG_BASE + 22'h2, 8'h11, 8'h11, 1'b0);
    chk("stall pin", 32'h1, {31'h0, stall});
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    u_cpu.rd(`MCON_OFS, q);
    chk("reset in write", 32'h1, {31'h0, q[3]});
    stop_test();
  end
endmodule : testbench
